/* design/sew_ee_loader.sv */
// automatic loader: reads the eight-word eeprom image in 16-bit organisation
// assumes rdata is already synchronised and start comes only while idle
`timescale 1ns/1ps
module sew_ee_loader
  import sew_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  sew_ee_if.loader ee
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SHIFT = 4'h2,
    ST_GAP = 4'h4,
    ST_DONE = 4'h8
  } sew_ld_state_t;

  sew_ld_state_t state, next_state;
  logic [7:0] div, next_div;
  logic [4:0] bitn, next_bitn;
  logic [2:0] word, next_word;
  logic [15:0] shreg, next_shreg;
  logic sk, next_sk;
  logic cs, next_cs;
  logic di, next_di;
  logic valid, next_valid;

  // command bit for a serial bit slot, zero once the address is out
  function automatic logic cmd_bit(input logic [4:0] slot, input logic [2:0] adr);
    logic [8:0] cmd;
    cmd = {READ_CMD, ADDR_BITS'(adr)};
    cmd_bit = (slot < CMD_BITS) ? cmd[4'(CMD_BITS - 5'h01 - slot)] : 1'b0;
  endfunction

  // ************************************************
  // serial sequencer
  // ************************************************
  // one bit period is 256 core cycles; data changes with the clock low
  always_comb begin
    next_state = state;
    next_div = div;
    next_bitn = bitn;
    next_word = word;
    next_shreg = shreg;
    next_valid = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (ee.start) begin
          next_state = ST_SHIFT;
          next_div = 8'h00;
          next_bitn = 5'h00;
          next_word = 3'h0;
        end
      end
      ST_SHIFT: begin
        next_div = div + 8'h01;
        // sample read data on the rising serial clock after the dummy zero
        if (div == EE_DIV_HALF && bitn > CMD_BITS) begin // R3
          next_shreg = {shreg[14:0], ee.rdata};
        end
        if (div == EE_DIV_LAST) begin
          if (bitn == WORD_CLOCKS - 5'h01) begin
            next_state = ST_GAP; // chip select drops for one bit period
            next_valid = 1'b1;
          end else begin
            next_bitn = bitn + 5'h01;
          end
        end
      end
      ST_GAP: begin
        next_div = div + 8'h01;
        if (div == EE_DIV_LAST) begin
          if (word == LAST_WORD) begin // R9
            next_state = ST_DONE;
          end else begin
            next_state = ST_SHIFT;
            next_word = word + 3'h1;
            next_bitn = 5'h00;
          end
        end
      end
      ST_DONE: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_cs = (next_state == ST_SHIFT);
    next_sk = (next_state == ST_SHIFT) && (next_div >= EE_DIV_HALF); // R1
    next_di = (next_state == ST_SHIFT) && cmd_bit(next_bitn, next_word); // R3
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      div <= 8'h00;
      bitn <= 5'h00;
      word <= 3'h0;
      shreg <= 16'h0000;
      sk <= 1'b0;
      cs <= 1'b0;
      di <= 1'b0;
      valid <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      bitn <= next_bitn;
      word <= next_word;
      shreg <= next_shreg;
      sk <= next_sk;
      cs <= next_cs;
      di <= next_di;
      valid <= next_valid;
    end
  end

  assign ee.sk = sk;
  assign ee.cs = cs;
  assign ee.di = di;
  assign ee.done = (state == ST_DONE);
  assign ee.word_valid = valid;
  assign ee.word_idx = word;
  assign ee.word_data = shreg;

  // ************************************************
  // checks
  // ************************************************
  logic [8:0] sk_gap; // cycles since the last rising serial clock
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sk_gap <= 9'h000;
    end else begin
      sk_gap <= (!sk && next_sk) ? 9'h001 : sk_gap + 9'h001;
    end
  end

  sequence ld_begin;
    ee.start && state == ST_IDLE;
  endsequence

  sequence first_clock;
    ee.cs && !ee.sk ##128 ee.cs && ee.sk;
  endsequence

  // looked at on the edge that launches a rise, while the counter still holds the full period
  sk_rate_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R1
    !sk && next_sk && bitn != 5'h00 |-> sk_gap == 9'(EE_DIV))
    else $error("serial clock period is not 256 core cycles");

  start_seq_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R1
    ld_begin |=> first_clock)
    else $error("load did not open with chip select and a half-period low clock");

  word_bits_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R3
    ee.word_valid |-> bitn == WORD_CLOCKS - 5'h01 && $past(cs, 2) && !cs)
    else $error("word ended after the wrong number of serial clocks");

  word_count_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R9
    $rose(ee.done) |-> word == LAST_WORD && $past(state) == ST_GAP)
    else $error("load finished before all eight words");

endmodule // sew_ee_loader

/* design/sew_strap_eeprom_wake.sv */
// strap sampling, eeprom line ownership and wake event of a dual uart
// assumes soft_reset_i and power state inputs come from core-clock logic
`timescale 1ns/1ps

// Function
// (R1) eeprom clock is core clock over 256 while loading
// (R2) software drives eeprom lines by manual control afterwards
// (R3) loader uses 16-bit word commands and data
// (R4) chip-select level at power-up shows eeprom fitted
// (R5) sample infrared strap at power-up, reset, soft reset
// (R6) infrared strap goes to modem control bit 6
// (R7) high half-duplex strap sets feature control bit 5
// (R8) wake pin low on uart event in D3hot
// (R9) eeprom image is eight 16-bit words
// (R10) manual control owns lines only after load ends
module sew_strap_eeprom_wake
  import sew_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  input wire logic infrared_strap_i,
  input wire logic half_duplex_strap_n_i,
  input wire logic eeprom_read_data_i,
  input wire logic eeprom_chip_select_i,
  input wire logic eeprom_manual_clock_i,
  input wire logic eeprom_manual_select_i,
  input wire logic eeprom_manual_write_i,
  input wire logic [2:0] image_addr_i,
  input wire logic d3hot_i,
  input wire logic pme_enable_i,
  input wire logic [1:0] rx_char_event_i,
  input wire logic [1:0] modem_change_i,
  output logic eeprom_serial_clock_o,
  output logic eeprom_chip_select_o,
  output logic eeprom_chip_select_oe_o,
  output logic eeprom_write_data_o,
  output logic eeprom_manual_read_o,
  output logic eeprom_present_o,
  output logic load_done_o,
  output logic [15:0] image_data_o,
  output logic strap_load_o,
  output logic modem_control_ir_o,
  output logic feature_control_485_o,
  output logic pme_n_o,
  output logic pme_oe_o
);

  sew_ee_if ee ();

  sew_ee_loader u_loader (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .ee(ee.loader)
  );

  // ************************************************
  // pin synchronisers
  // ************************************************
  // order: read data, chip-select sense, infrared strap, half-duplex strap
  logic [3:0] pin_meta, pin_sync;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {eeprom_read_data_i, eeprom_chip_select_i, infrared_strap_i,
                   half_duplex_strap_n_i};
      pin_sync <= pin_meta;
    end
  end

  logic rdata_s, cs_sense_s, ir_s, hd_s;
  assign {rdata_s, cs_sense_s, ir_s, hd_s} = pin_sync;
  assign ee.rdata = rdata_s;

  // ************************************************
  // control state
  // ************************************************
  logic [1:0] settle, next_settle;
  logic boot, next_boot;
  logic ld_start, next_ld_start;
  logic ld_active, next_ld_active;
  logic manual, next_manual;
  logic present, next_present;
  logic take_q, next_take_q;
  logic ir_bit, next_ir_bit;
  logic hd_bit, next_hd_bit;
  logic pend, next_pend;
  logic pme_n_q, next_pme_n_q;
  logic sk_q, next_sk_q;
  logic cs_q, next_cs_q;
  logic cs_oe_q, next_cs_oe_q;
  logic di_q, next_di_q;
  logic mrd_q, next_mrd_q;
  logic [15:0] img_q, next_img_q;
  logic [15:0] image [IMAGE_WORDS];
  logic take, arm, uart_event;

  // strap pickup waits for the synchronisers after any reset; the eeprom
  // load runs only after the power-up or hardware reset, not a soft reset
  always_comb begin
    take = (settle == STRAP_TAKE);
    next_settle = soft_reset_i ? STRAP_SETTLE : (settle != 2'h0) ? settle - 2'h1 : settle;
    next_take_q = take; // R5
    next_boot = boot && !take;
    next_present = (take && boot) ? cs_sense_s : present; // R4
    next_ld_start = take && boot && cs_sense_s; // R4
    next_ld_active = ld_active || ld_start;
    // no eeprom means nothing to load, so software owns the lines at once
    next_manual = manual || (take && boot && !cs_sense_s) || ee.done; // R10
    next_ir_bit = take ? ir_s : ir_bit; // R5 R6
    next_hd_bit = take ? hd_s : hd_bit; // R7
    arm = d3hot_i && pme_enable_i;
    uart_event = |{rx_char_event_i, modem_change_i};
    next_pend = arm && (pend || uart_event); // R8
    next_pme_n_q = !next_pend; // R8
    // line source: manual after the load, loader during it, released before
    if (manual) begin // R2 R10
      next_sk_q = eeprom_manual_clock_i;
      next_cs_q = eeprom_manual_select_i;
      next_cs_oe_q = 1'b1;
      next_di_q = eeprom_manual_write_i;
      next_mrd_q = rdata_s;
    end else if (ld_active) begin // R1 R10
      next_sk_q = ee.sk;
      next_cs_q = ee.cs;
      next_cs_oe_q = 1'b1;
      next_di_q = ee.di;
      next_mrd_q = 1'b0;
    end else begin // R4
      next_sk_q = 1'b0;
      next_cs_q = 1'b0;
      next_cs_oe_q = 1'b0; // pull-up must be readable while sensing
      next_di_q = 1'b0;
      next_mrd_q = 1'b0;
    end
    next_img_q = image[image_addr_i];
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      settle <= STRAP_SETTLE;
      boot <= 1'b1;
      present <= 1'b0;
      ld_start <= 1'b0;
      ld_active <= 1'b0;
      manual <= 1'b0;
      take_q <= 1'b0;
      ir_bit <= 1'b0;
      hd_bit <= 1'b0;
      pend <= 1'b0;
      pme_n_q <= 1'b1;
      sk_q <= 1'b0;
      cs_q <= 1'b0;
      cs_oe_q <= 1'b0;
      di_q <= 1'b0;
      mrd_q <= 1'b0;
      img_q <= 16'h0000;
    end else begin
      settle <= next_settle;
      boot <= next_boot;
      present <= next_present;
      ld_start <= next_ld_start;
      ld_active <= next_ld_active;
      manual <= next_manual;
      take_q <= next_take_q;
      ir_bit <= next_ir_bit;
      hd_bit <= next_hd_bit;
      pend <= next_pend;
      pme_n_q <= next_pme_n_q;
      sk_q <= next_sk_q;
      cs_q <= next_cs_q;
      cs_oe_q <= next_cs_oe_q;
      di_q <= next_di_q;
      mrd_q <= next_mrd_q;
      img_q <= next_img_q;
    end
  end

  // image store, written once per word by the loader
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < IMAGE_WORDS; i++) begin
        image[i] <= 16'h0000;
      end
    end else if (ee.word_valid) begin // R9
      image[ee.word_idx] <= ee.word_data;
    end
  end

  assign ee.start = ld_start;

  // ************************************************
  // outputs, all straight from flip-flops
  // ************************************************
  assign eeprom_serial_clock_o = sk_q;
  assign eeprom_chip_select_o = cs_q;
  assign eeprom_chip_select_oe_o = cs_oe_q;
  assign eeprom_write_data_o = di_q;
  assign eeprom_manual_read_o = mrd_q;
  assign eeprom_present_o = present;
  assign load_done_o = manual;
  assign image_data_o = img_q;
  assign strap_load_o = take_q;
  assign modem_control_ir_o = ir_bit;
  assign feature_control_485_o = hd_bit; // uart applies it to bit FEATURE_CONTROL_REG_485_BIT
  assign pme_n_o = pme_n_q; // open drain: low only while enabled
  assign pme_oe_o = pend;

  // ************************************************
  // checks
  // ************************************************
  sequence soft_req;
    soft_reset_i ##1 !soft_reset_i [*3];
  endsequence

  soft_take_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R5
    soft_req |=> strap_load_o)
    else $error("straps not resampled three cycles after soft reset");

  ir_copy_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R6
    take |=> modem_control_ir_o == $past(ir_s) && strap_load_o)
    else $error("infrared strap not copied to modem control bit");

  hd_copy_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R7
    strap_load_o ##1 !strap_load_o |-> $stable(feature_control_485_o))
    else $error("auto direction bit changed without a strap sample");

  hd_value_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R7
    take && hd_s |=> feature_control_485_o)
    else $error("high half-duplex strap did not set auto direction");

  absent_skip_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R4
    take && boot && !cs_sense_s |=> ##[1:2] load_done_o && !ld_active)
    else $error("missing eeprom did not hand lines to software");

  pme_set_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R8
    arm && uart_event |=> !pme_n_o && pme_oe_o)
    else $error("wake pin not driven after event in D3hot");

  pme_quiet_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R8
    !arm |=> pme_n_o && !pme_oe_o)
    else $error("wake pin driven while not armed");

  manual_path_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R2
    manual |=> eeprom_serial_clock_o == $past(eeprom_manual_clock_i)
      && eeprom_write_data_o == $past(eeprom_manual_write_i))
    else $error("manual control does not reach the eeprom lines");

  owner_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // R10
    ld_active && !manual |=> eeprom_chip_select_o == $past(ee.cs)
      && eeprom_serial_clock_o == $past(ee.sk))
    else $error("manual control reached the lines during the load");

endmodule // sew_strap_eeprom_wake

/* shared/sew_ee_if.sv */
// link between the top control logic and the automatic eeprom loader
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface sew_ee_if;
  logic start; // one-cycle pulse, begin the automatic load
  logic done; // level, load finished
  logic sk;
  logic cs;
  logic di;
  logic rdata; // synchronised eeprom_read_data
  logic word_valid; // one-cycle pulse with word_idx and word_data
  logic [2:0] word_idx;
  logic [15:0] word_data;
  modport loader (input start, rdata, output done, sk, cs, di, word_valid, word_idx, word_data);
  modport ctrl (output start, rdata, input done, sk, cs, di, word_valid, word_idx, word_data);
endinterface

/* shared/sew_pkg.sv */
// constants shared by the strap, eeprom loader and wake logic
// assumes one 250 MHz core clock and a synchronous active-high reset
package sew_pkg;

  // ************************************************
  // eeprom serial timing and image layout
  // ************************************************
  localparam int EE_DIV = 256; // serial clock = core clock / 256
  localparam logic [7:0] EE_DIV_LAST = 8'hff; // last core cycle of a serial bit
  localparam logic [7:0] EE_DIV_HALF = 8'h80; // serial clock rises here
  localparam int IMAGE_WORDS = 8;
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 6;
  localparam logic [4:0] CMD_BITS = 5'h09; // start bit, opcode, address
  localparam logic [4:0] WORD_CLOCKS = 5'h1a; // command, dummy zero, 16 data bits
  localparam logic [2:0] READ_CMD = 3'h6; // start bit 1 then read opcode 10
  localparam logic [2:0] LAST_WORD = 3'h7;

  // ************************************************
  // strap sampling and register bit positions
  // ************************************************
  localparam logic [1:0] STRAP_SETTLE = 2'h3; // lets the two sync stages fill
  localparam logic [1:0] STRAP_TAKE = 2'h1;
  localparam int MCR_IR_BIT = 6; // infrared enable in modem_control_reg
  localparam int FEATURE_CONTROL_REG_485_BIT = 5; // auto direction in feature_control_reg

endpackage

/* tb/sew_eeprom_model.sv */
// behavioural serial eeprom in 16-bit organisation, answers every command as a read
// assumes sk and cs are the pad levels seen by the eeprom, seed_i sets contents
`timescale 1ns/1ps
module sew_eeprom_model (
  input wire logic sk_i,
  input wire logic cs_i,
  input wire logic di_i,
  input wire logic [15:0] seed_i,
  output logic do_o
);
  int n = 0;
  logic [8:0] sh = 9'h000;
  logic [5:0] a;
  logic [15:0] w;

  // ************************************************
  // command shift and data answer
  // ************************************************
  // word contents follow the address so a wrong address shows as wrong data
  assign a = sh[5:0];
  assign w = seed_i ^ {a, a, a[3:0]};

  // count rising clocks while selected, take start, opcode and address bits
  always @(posedge sk_i or negedge cs_i) begin
    if (!cs_i) begin
      n <= 0;
    end else begin
      n <= n + 1;
      if (n < 9) begin
        sh <= {sh[7:0], di_i};
      end
    end
  end

  // output changes on the falling clock so it is stable at the next rise
  always @(negedge sk_i) begin
    if (cs_i && n == 9) begin
      do_o <= 1'b0;
    end else if (cs_i && n >= 10 && n <= 25) begin
      do_o <= w[25-n];
    end
  end

  // released line: shows the inverse of the last value, never a held copy
  always @(negedge cs_i) begin
    do_o <= ~do_o;
  end

  initial do_o = 1'b0;
endmodule // sew_eeprom_model

/* tb/testbench.sv */
// self-checking bench for strap sampling, eeprom loading, manual control, wake
// assumes the pad of chip select has a pull-up unless absent is set
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  import sew_pkg::*;
  logic core_clk_i = 1'b0, reset_i = 1'b1, soft_reset_i = 1'b0, ir = 1'b0, hd = 1'b0;
  logic mck = 1'b0, msel = 1'b0, mwr = 1'b0, d3 = 1'b0, pen = 1'b0, absent = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [1:0] rxe = 2'h0, mce = 2'h0;
  logic [15:0] seed = 16'h0000, got;
  logic [8:0] cmd;
  logic sk, cs, cs_oe, di, rd, cs_pad, mrd, present, done, sload, mcr_ir, feature_control_reg_485;
  logic pme_n, pme_oe;
  logic [15:0] image;
  int mismatches = 0, compares = 0, n, i, k;

  // ************************************************
  // clock, pad and instances
  // ************************************************
  // 250 MHz core clock
  always #2 core_clk_i = ~core_clk_i;
  assign cs_pad = cs_oe ? cs : !absent; // pull-up unless the eeprom is taken away

  sew_strap_eeprom_wake dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .soft_reset_i(soft_reset_i), .infrared_strap_i(ir), .half_duplex_strap_n_i(hd),
    .eeprom_read_data_i(rd), .eeprom_chip_select_i(cs_pad), .eeprom_manual_clock_i(mck),
    .eeprom_manual_select_i(msel), .eeprom_manual_write_i(mwr), .image_addr_i(addr),
    .d3hot_i(d3), .pme_enable_i(pen), .rx_char_event_i(rxe), .modem_change_i(mce),
    .eeprom_serial_clock_o(sk), .eeprom_chip_select_o(cs), .eeprom_chip_select_oe_o(cs_oe),
    .eeprom_write_data_o(di), .eeprom_manual_read_o(mrd), .eeprom_present_o(present),
    .load_done_o(done), .image_data_o(image), .strap_load_o(sload),
    .modem_control_ir_o(mcr_ir), .feature_control_485_o(feature_control_reg_485), .pme_n_o(pme_n),
    .pme_oe_o(pme_oe));
  sew_eeprom_model ee_u (.sk_i(sk), .cs_i(cs_pad), .di_i(di), .seed_i(seed), .do_o(rd));

  // ************************************************
  // tasks and expectations
  // ************************************************
  function automatic logic [15:0] word_of(input logic [2:0] a);
    return seed ^ {3'h0, a, 3'h0, a, 1'b0, a};
  endfunction

  task automatic complete_run();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // leaves the bench at a falling edge, where inputs change
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  // request seen on the first edge here, straps taken on the third edge after it
  task automatic strap_check(input logic eir, input logic ehd);
    tick(1);
    soft_reset_i = 1'b0;
    reset_i = 1'b0;
    tick(2);
    `CHK("strap_load early", 1'b0, sload)
    tick(1);
    `CHK("strap_load", 1'b1, sload)
    `CHK("modem ir bit", eir, mcr_ir)
    `CHK("feature 485 bit", ehd, feature_control_reg_485)
  endtask

  task automatic wait_done(input int lim);
    for (k = 0; k < lim && done !== 1'b1; k++) tick(1);
    if (done !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask

  task automatic wait_sk_rise(output int c);
    logic p;
    p = sk;
    for (c = 1; c < 600; c++) begin
      tick(1);
      if (sk === 1'b1 && p === 1'b0) return;
      p = sk;
    end
    mismatches++;
    complete_run();
  endtask

  // one slow manual serial bit, read data looked at well after the rise
  task automatic man_bit(input logic b);
    mwr = b;
    mck = 1'b0;
    tick(8);
    mck = 1'b1;
    tick(8);
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    void'($urandom(32'h4c24075d));
    seed = 16'($urandom);
    ir = 1'($urandom);
    hd = 1'($urandom);
    // four reset edges, the last one inside strap_check
    tick(3);
    strap_check(ir, hd);
    `CHK("present", 1'b1, present)
    `CHK("cs released", 1'b0, cs_oe)
    // manual clock held high: the pad must still toggle at the divided rate
    mck = 1'b1;
    wait_sk_rise(n);
    cmd = {8'h00, di};
    for (i = 0; i < 8; i++) begin
      wait_sk_rise(n);
      cmd = {cmd[7:0], di};
      if (i == 0) `CHK("sk period", 256, n)
    end
    `CHK("read command", 9'h180, cmd)
    `CHK("manual read early", 1'b0, mrd)
    `CHK("done early", 1'b0, done)
    mck = 1'b0;
    wait_done(60000);
    for (i = 0; i < IMAGE_WORDS; i++) begin
      addr = 3'(i);
      tick(1);
      `CHK("image word", word_of(3'(i)), image)
    end
    // manual pins follow the control bits one edge later
    for (i = 0; i < 6; i++) begin
      {mck, msel, mwr} = (i == 5) ? 3'h0 : 3'($urandom);
      tick(1);
      `CHK("manual sk", mck, sk)
      `CHK("manual cs", msel, cs)
      `CHK("manual di", mwr, di)
      `CHK("manual cs drive", 1'b1, cs_oe)
    end
    // full manual read of a random word through the control bits
    addr = 3'($urandom);
    msel = 1'b1;
    tick(8);
    cmd = {6'h30, addr};
    for (i = 8; i >= 0; i--) man_bit(cmd[i]);
    man_bit(1'b0);
    for (i = 15; i >= 0; i--) begin
      man_bit(1'b0);
      got[i] = mrd;
    end
    msel = 1'b0;
    tick(4);
    `CHK("manual word", word_of(addr), got)
    // soft reset resamples every strap combination, load stays finished
    for (i = 0; i < 4; i++) begin
      {hd, ir} = 2'(i);
      soft_reset_i = 1'b1;
      strap_check(ir, hd);
      `CHK("done kept", 1'b1, done)
    end
    // wake: only all three of power state, enable and an event assert it
    for (i = 0; i < 8; i++) begin
      {rxe, mce} = i[2] ? 4'(1 << ($urandom % 4)) : 4'h0;
      {pen, d3} = 2'(i);
      tick(1);
      `CHK("pme_n", i != 7, pme_n)
      `CHK("pme_oe", i == 7, pme_oe)
      {rxe, mce} = 4'h0;
      tick(2);
      `CHK("pme_n held", i != 7, pme_n)
      {pen, d3} = 2'h0;
      tick(1);
      `CHK("pme_n released", 1'b1, pme_n)
    end
    // hardware reset with no eeprom on the pad: load skipped
    reset_i = 1'b1;
    absent = 1'b1;
    tick(3);
    strap_check(ir, hd);
    `CHK("absent", 1'b0, present)
    wait_done(20);
    `CHK("skip done", 1'b1, done)
    complete_run();
  end
endmodule // testbench
